// ### logic/dbg_mon_pkg.sv
/*
  Constants, codes and carriers of the serial debug monitor.
  Assumes a single system clock at 10 MHz; no software registers.
*/
package dbg_mon_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned BAUD_DIVISOR    = 278;
  localparam int unsigned BIT_CYCLES      = BAUD_DIVISOR;
  localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int unsigned BREAK_ZERO_BITS = 10;
  localparam int unsigned ECHO_GAP_BITS   = 2;
  localparam int unsigned CANCEL_BITS     = 11;
  localparam int unsigned SEC_BYTES       = 8;
  localparam int unsigned FIFO_DEPTH      = 8;

  // ****************************************************************
  // Addresses and fields
  // ****************************************************************
  localparam logic [15:0] SEC_BASE_ADDR   = 16'hFFF6;
  localparam logic [15:0] SEC_LAST_ADDR   = 16'hFFFD;
  localparam logic [15:0] FLAG_RAM_ADDR   = 16'h0040;
  localparam int unsigned FLAG_OK_BIT     = 6;
  localparam logic [15:0] VEC_RESET_USER  = 16'hFFFE;
  localparam logic [15:0] VEC_RESET_MON   = 16'hFEFE;
  localparam logic [15:0] VEC_SWI_USER    = 16'hFFFC;
  localparam logic [15:0] VEC_SWI_MON     = 16'hFEFC;
  localparam logic [15:0] FLASH_BASE_ADDR = 16'h8000;
  localparam logic [7:0]  INVALID_DATA    = 8'h00;
  localparam logic [15:0] SP_RESET        = 16'h00FF;
  localparam logic [15:0] SP_INC          = 16'h0001;
  localparam logic [15:0] SP_PUSH_FRAME   = 16'h0006;

  // ****************************************************************
  // Command opcodes
  // ****************************************************************
  localparam logic [7:0] CMD_READ   = 8'h4A;
  localparam logic [7:0] CMD_WRITE  = 8'h49;
  localparam logic [7:0] CMD_INDEXED_READ_CMD  = 8'h1A;
  localparam logic [7:0] CMD_INDEXED_WRITE_CMD = 8'h19;
  localparam logic [7:0] CMD_RDSP   = 8'h0C;
  localparam logic [7:0] CMD_RUN    = 8'h28;

  localparam logic [1:0] DIV_BY_TWO  = 2'd1;
  localparam logic [1:0] DIV_BY_FOUR = 2'd2;

  // Memory request toward the system bus
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_req_s;

  // Latched mode bits
  typedef struct packed {
    logic       monitor;
    logic       forced;
    logic [1:0] clk_div;
  } mode_s;

endpackage : dbg_mon_pkg

// ### logic/byte_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and asynchronous active-high reset.
*/
`timescale 1ns/1ps
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_no_overflow : assert property (@(posedge clk_sys) disable iff (rst)
    count <= DEPTH[AW:0]) else $error("fifo count above depth");

endmodule : byte_fifo

// ### logic/monitor_serial_debug.sv
/*
  Serial debug monitor: mode latch, security entry, byte echo and commands.
  Assumes serial input is synchronous to clk_sys and the line is pulled up
  externally; memory answers a read one cycle after the request.
*/
// Summary of operation
// - Latch monitor mode at reset pin rising edge
// - Await eight security bytes, then send break; break at once if bypass already set
// - High voltage entry: divide select picks two/four
// - High voltage entry: watchdog off while voltage present
// - Forced mode ignores selects, divides by four
// - Forced mode always disables watchdog
// - Monitor mode fetches vectors from page FE
// - NRZ framing, equal transmit and receive rates
// - Received break: release two bits, echo break
// - Bit rate is bus clock over 278
// - Echo every received byte
// - Eleven bit pause after command; break cancels
// - Two bit gap before echo and data
// - Read data follows echo of last byte
// - Entry pushes index high; run pulls, returns; code only offsets stack_pointer at reset, run only sets run_user
// - Stack read returns pointer plus one
// - Security bytes must all match flash
// - Bypass survives all but power-on reset
// - Failed match: invalid flash reads, execute reset
// - Set bit six of location 0x40 on success
// - No ready break before eighth security byte; code sends it at once when the bypass is already set
// - Serial pin only pulled low, open drain
`timescale 1ns/1ps
module monitor_serial_debug
  import dbg_mon_pkg::*;
(
  // Clock and resets
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                por,
  // Entry straps
  input  wire logic                reset_pin_n,
  input  wire logic                irq_high_voltage,
  input  wire logic                rst_high_voltage,
  input  wire logic                clock_divide_select_pin,
  input  wire logic                reset_vector_blank,
  // Serial pin, open drain
  input  wire logic                serial_comm_pin_in,
  output logic                     serial_comm_pin_out,
  output logic                     serial_comm_pin_oe_n,
  // Memory port
  output dbg_mon_pkg::mem_req_s    mem_req,
  input  wire logic [7:0]          mem_rdata,
  input  wire logic                flash_exec_attempt,
  // Mode outputs
  output dbg_mon_pkg::mode_s       mode,
  output logic                     watchdog_disable,
  output logic [15:0]              reset_vector_addr,
  output logic [15:0]              swi_vector_addr,
  output logic                     security_ok,
  output logic                     illegal_addr_reset,
  output logic                     run_user
);
  import dbg_mon_pkg::*;

  typedef enum logic [6:0] {
    S_SEC   = 7'b000_0001,
    S_READY = 7'b000_0010,
    S_CMD   = 7'b000_0100,
    S_OPER  = 7'b000_1000,
    S_EXEC  = 7'b001_0000,
    S_DATA  = 7'b010_0000,
    S_PAUSE = 7'b100_0000
  } ctl_e;

  // ****************************************************************
  // Mode latch
  // ****************************************************************
  logic reset_pin_q;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      reset_pin_q <= 1'b0;
      mode        <= '0;
    end
    else
    begin
      reset_pin_q <= reset_pin_n;
      // Straps caught on release only; later pin changes leave the mode bits alone
      if (reset_pin_n && !reset_pin_q)
      begin
        mode.monitor <= irq_high_voltage || reset_vector_blank;
        mode.forced  <= !irq_high_voltage && reset_vector_blank;
        mode.clk_div <= (irq_high_voltage && !clock_divide_select_pin) ?
                        DIV_BY_TWO : DIV_BY_FOUR;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      watchdog_disable  <= 1'b0;
      reset_vector_addr <= VEC_RESET_USER;
      swi_vector_addr   <= VEC_SWI_USER;
    end
    else
    begin
      watchdog_disable  <= mode.forced ||
                           (mode.monitor && (irq_high_voltage || rst_high_voltage));
      reset_vector_addr <= mode.monitor ? VEC_RESET_MON : VEC_RESET_USER;
      swi_vector_addr   <= mode.monitor ? VEC_SWI_MON : VEC_SWI_USER;
    end
  end

  // ****************************************************************
  // Receiver: NRZ 8N1, bit = 278 bus cycles
  // ****************************************************************
  logic [8:0] rx_cnt;
  logic [3:0] rx_bit;
  logic       rx_busy;
  logic [7:0] rx_shift;
  logic       rx_byte;
  logic       rx_break;
  logic [7:0] rx_data;
  logic       rx_prev;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rx_cnt   <= '0;
      rx_bit   <= '0;
      rx_busy  <= 1'b0;
      rx_shift <= '0;
      rx_byte  <= 1'b0;
      rx_break <= 1'b0;
      rx_data  <= '0;
      rx_prev  <= 1'b1;
    end
    else
    begin
      rx_byte  <= 1'b0;
      rx_break <= 1'b0;
      rx_prev  <= serial_comm_pin_in;
      if (!rx_busy)
      begin
        // Falling edge only, so the low tail of a break cannot open a frame
        if (rx_prev && !serial_comm_pin_in && serial_comm_pin_oe_n)
        begin
          rx_busy <= 1'b1;
          rx_cnt  <= 9'(HALF_BIT_CYCLES);
          rx_bit  <= '0;
        end
      end
      else if (rx_cnt != '0)
      begin
        rx_cnt <= rx_cnt - 1'b1;
      end
      else
      begin
        rx_cnt <= 9'(BIT_CYCLES - 1);
        rx_bit <= rx_bit + 1'b1;
        if (rx_bit >= 4'd1 && rx_bit <= 4'd8)
        begin
          rx_shift <= {serial_comm_pin_in, rx_shift[7:1]};
        end
        if (rx_bit == 4'(BREAK_ZERO_BITS - 1))
        begin
          rx_busy <= 1'b0;
          // Zero stop bit after nine zeros marks a break
          if (!serial_comm_pin_in && rx_shift == 8'h00)
          begin
            rx_break <= 1'b1;
          end
          else
          begin
            rx_byte <= 1'b1;
            rx_data <= rx_shift;
          end
        end
      end
    end
  end

  // ****************************************************************
  // Transmit FIFO and transmitter
  // ****************************************************************
  logic       q_valid;
  logic       q_ready;
  logic [8:0] q_data;
  logic       f_valid;
  logic       f_ready;
  logic [8:0] f_data;

  byte_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (q_valid),
    .in_ready  (q_ready),
    .in_data   (q_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // Entry bit 8 set means break; every frame leads with a 2-bit idle gap
  logic [8:0]  tx_cnt;
  logic [4:0]  tx_bit;
  logic        tx_busy;
  logic [11:0] tx_frame;
  logic        tx_is_brk;

  assign f_ready = !tx_busy;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tx_cnt               <= '0;
      tx_bit               <= '0;
      tx_busy              <= 1'b0;
      tx_frame             <= '1;
      tx_is_brk            <= 1'b0;
      serial_comm_pin_out  <= 1'b0;
      serial_comm_pin_oe_n <= 1'b1;
    end
    else
    begin
      serial_comm_pin_out <= 1'b0;
      if (!tx_busy && f_valid)
      begin
        tx_busy   <= 1'b1;
        tx_cnt    <= 9'(BIT_CYCLES - 1);
        tx_bit    <= '0;
        tx_is_brk <= f_data[8];
        tx_frame  <= f_data[8] ? 12'b0000_0000_0011 :
                     {1'b1, f_data[7:0], 1'b0, 2'b11};
      end
      else if (tx_busy)
      begin
        // Low bit of the frame is the current bit time
        serial_comm_pin_oe_n <= (tx_is_brk && tx_bit >= 5'(ECHO_GAP_BITS)) ?
                                1'b0 : tx_frame[0];
        if (tx_cnt != '0)
        begin
          tx_cnt <= tx_cnt - 1'b1;
        end
        else
        begin
          tx_cnt   <= 9'(BIT_CYCLES - 1);
          tx_bit   <= tx_bit + 1'b1;
          tx_frame <= {1'b1, tx_frame[11:1]};
          // Gap plus ten bit times, for a byte frame and a break alike
          if (tx_bit == 5'(ECHO_GAP_BITS + BREAK_ZERO_BITS - 1))
          begin
            tx_busy              <= 1'b0;
            serial_comm_pin_oe_n <= 1'b1;
          end
        end
      end
      else
      begin
        serial_comm_pin_oe_n <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Command control
  // ****************************************************************
  ctl_e        state;
  logic [7:0]  cmd;
  logic [2:0]  opnd_left;
  logic [15:0] addr;
  logic [15:0] stack_pointer;
  logic [3:0]  sec_idx;
  logic        sec_match;
  logic        sec_bypass;
  logic [12:0] pause_cnt;
  logic        data_hi;
  logic        mem_rd_q;
  logic        flash_region;
  logic        q_echo;
  logic        q_brk;
  logic [7:0]  wr_data;
  logic [15:0] sp_plus_one;
  logic [15:0] rd_addr;

  // Address has already stepped past the byte being returned
  assign rd_addr      = addr - 16'h0001;
  assign flash_region = (rd_addr >= FLASH_BASE_ADDR);
  assign sp_plus_one  = stack_pointer + SP_INC;
  assign q_echo       = rx_byte;
  assign q_brk        = rx_break || (state == S_READY);
  assign q_valid      = q_echo || q_brk || mem_rd_q || (state == S_DATA);
  assign q_data       = q_brk ? 9'h100 :
                        q_echo ? {1'b0, rx_data} :
                        mem_rd_q ? {1'b0, (flash_region && !sec_bypass) ?
                                    INVALID_DATA : mem_rdata} :
                        {1'b0, data_hi ? sp_plus_one[15:8] : sp_plus_one[7:0]};

  // Power-on reset alone clears the bypass
  always_ff @(posedge clk_sys or posedge por)
  begin
    if (por)
    begin
      sec_bypass <= 1'b0;
    end
    else if (state == S_SEC && rx_byte && sec_idx == 4'(SEC_BYTES - 1) &&
             sec_match && rx_data == mem_rdata)
    begin
      sec_bypass <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state              <= S_SEC;
      cmd                <= '0;
      opnd_left          <= '0;
      addr               <= '0;
      stack_pointer      <= SP_RESET - SP_PUSH_FRAME;
      sec_idx            <= '0;
      sec_match          <= 1'b1;
      pause_cnt          <= '0;
      data_hi            <= 1'b0;
      mem_rd_q           <= 1'b0;
      wr_data            <= '0;
      mem_req            <= '0;
      security_ok        <= 1'b0;
      illegal_addr_reset <= 1'b0;
      run_user           <= 1'b0;
    end
    else
    begin
      mem_req            <= '0;
      // A command read is issued on the move into the pause state
      mem_rd_q           <= mem_req.rd && state == S_PAUSE;
      illegal_addr_reset <= flash_exec_attempt && !sec_bypass;
      security_ok        <= sec_bypass;
      unique case (state)
        S_SEC:
        begin
          mem_req.rd   <= 1'b1;
          mem_req.addr <= SEC_BASE_ADDR + 16'(sec_idx);
          if (sec_bypass && mode.monitor && !rx_busy && sec_idx == 4'd0 && !por)
          begin
            state <= S_READY;
          end
          else if (rx_byte)
          begin
            sec_match <= sec_match && (rx_data == mem_rdata);
            sec_idx   <= sec_idx + 1'b1;
            if (sec_idx == 4'(SEC_BYTES - 1))
            begin
              state <= S_READY;
            end
          end
        end
        S_READY:
        begin
          // Flag byte in RAM tells the host whether flash is open
          mem_req.wr    <= 1'b1;
          mem_req.addr  <= FLAG_RAM_ADDR;
          mem_req.wdata <= 8'(sec_bypass) << FLAG_OK_BIT;
          state         <= S_CMD;
        end
        S_CMD:
        begin
          if (rx_byte)
          begin
            cmd <= rx_data;
            unique case (rx_data)
              CMD_READ:   begin opnd_left <= 3'd2; state <= S_OPER; end
              CMD_WRITE:  begin opnd_left <= 3'd3; state <= S_OPER; end
              CMD_INDEXED_WRITE_CMD: begin opnd_left <= 3'd1; state <= S_OPER; end
              CMD_INDEXED_READ_CMD, CMD_RDSP, CMD_RUN:
                          begin opnd_left <= 3'd0; state <= S_EXEC; end
              default:    state <= S_CMD;
            endcase
          end
        end
        S_OPER:
        begin
          if (rx_byte)
          begin
            opnd_left <= opnd_left - 1'b1;
            if (opnd_left == 3'd1 && (cmd == CMD_WRITE || cmd == CMD_INDEXED_WRITE_CMD))
            begin
              wr_data <= rx_data;
            end
            else
            begin
              addr <= {addr[7:0], rx_data};
            end
            if (opnd_left == 3'd1)
            begin
              state <= S_EXEC;
            end
          end
        end
        S_EXEC:
        begin
          // Waits for the echo to leave so data follows it
          if (!rx_busy && !f_valid && !tx_busy && !mem_rd_q)
          begin
            mem_req.addr <= addr;
            if (cmd == CMD_READ || cmd == CMD_INDEXED_READ_CMD)
            begin
              mem_req.rd <= 1'b1;
              addr       <= addr + 16'h0001;
            end
            if (cmd == CMD_WRITE || cmd == CMD_INDEXED_WRITE_CMD)
            begin
              mem_req.wr    <= 1'b1;
              mem_req.wdata <= wr_data;
              addr          <= addr + 16'h0001;
            end
            if (cmd == CMD_RUN)
            begin
              run_user <= 1'b1;
            end
            data_hi <= 1'b1;
            state   <= (cmd == CMD_RDSP) ? S_DATA : S_PAUSE;
          end
        end
        S_DATA:
        begin
          // Pointer plus one leaves high byte first, then low byte
          data_hi <= 1'b0;
          if (!data_hi)
          begin
            state <= S_PAUSE;
          end
        end
        S_PAUSE:
        begin
          if (rx_break)
          begin
            pause_cnt <= '0;
            state     <= S_CMD;
          end
          else if (!tx_busy && !f_valid)
          begin
            pause_cnt <= pause_cnt + 1'b1;
            if (pause_cnt == 13'(CANCEL_BITS * BIT_CYCLES - 1))
            begin
              pause_cnt <= '0;
              state     <= S_CMD;
            end
          end
        end
      endcase
    end
  end

  a_ready_after_eight : assert property (@(posedge clk_sys) disable iff (rst)
    state == S_READY |-> (sec_idx == 4'(SEC_BYTES) || sec_bypass))
    else $error("ready break before security bytes");

  a_vector_monitor : assert property (@(posedge clk_sys) disable iff (rst)
    mode.monitor |=> reset_vector_addr == VEC_RESET_MON)
    else $error("monitor reset vector wrong");

  a_forced_watchdog : assert property (@(posedge clk_sys) disable iff (rst)
    mode.forced |=> watchdog_disable)
    else $error("watchdog live in forced mode");

  a_forced_div_four : assert property (@(posedge clk_sys) disable iff (rst)
    mode.forced |-> mode.clk_div == DIV_BY_FOUR)
    else $error("forced mode divider wrong");

  a_echo_queued : assert property (@(posedge clk_sys) disable iff (rst)
    rx_byte && q_ready |-> q_valid && q_data[7:0] == rx_data)
    else $error("received byte not echoed");

  a_line_open_drain : assert property (@(posedge clk_sys) disable iff (rst)
    serial_comm_pin_out == 1'b0)
    else $error("serial pin driven high");

  a_flash_blocked : assert property (@(posedge clk_sys) disable iff (rst || por)
    flash_exec_attempt && !sec_bypass |=> illegal_addr_reset)
    else $error("flash execute not trapped");

  a_flag_written : assert property (@(posedge clk_sys) disable iff (rst)
    state == S_READY |=> mem_req.wr && mem_req.addr == FLAG_RAM_ADDR)
    else $error("security flag not written");

  // Every frame, echo, data or break, opens with the line released
  sequence s_frame_load;
    !tx_busy && f_valid;
  endsequence

  sequence s_gap_released;
    serial_comm_pin_oe_n ##278 serial_comm_pin_oe_n;
  endsequence

  a_gap_before_frame : assert property (@(posedge clk_sys) disable iff (rst)
    s_frame_load |=> s_gap_released)
    else $error("frame gap not released");

endmodule : monitor_serial_debug

// ### dv/host_link.sv
/*
  Host side of the serial monitor link: pulled-up wire, byte send, byte receive.
  Assumes the device pulls the pin low only while its enable is low.
*/
`timescale 1ns/1ps
module host_link
(
  // Clock
  input  wire logic clk_sys,
  // Device side of the pin
  input  wire logic dev_out,
  input  wire logic dev_oe_n,
  // Resolved line
  output logic      line
);
  import dbg_mon_pkg::*;
  logic host_drv = 1'b1;

  // Pull-up: either party can only pull low
  assign line = host_drv & (dev_oe_n | dev_out);

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    @(posedge clk_sys);
    #1;
    for (int i = 0; i < 10; i++)
    begin
      host_drv = frame[i];
      repeat (BIT_CYCLES) @(posedge clk_sys);
      #1;
    end
  endtask : send_byte

  task automatic recv_byte(output logic [7:0] d, output logic stopb,
                           output logic ok, output int gap);
    gap = 0;
    while (line === 1'b1 && gap < 20 * BIT_CYCLES)
    begin
      @(posedge clk_sys);
      #1;
      gap++;
    end
    ok = (line === 1'b0);
    repeat (HALF_BIT_CYCLES) @(posedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYCLES) @(posedge clk_sys);
      d[i] = line;
    end
    repeat (BIT_CYCLES) @(posedge clk_sys);
    stopb = line;
    // Hold off one bit after each echo before the next byte
    repeat (HALF_BIT_CYCLES + BIT_CYCLES) @(posedge clk_sys);
    #1;
  endtask : recv_byte
endmodule : host_link

// ### dv/testbench.sv
/*
  Self-checking bench of the serial debug monitor: entry, security, read.
  Assumes a memory answering one cycle after each request.
*/
`timescale 1ns/1ps
module testbench;
  import dbg_mon_pkg::*;
  logic        clk_sys     = 1'b0;
  logic        rst         = 1'b1;
  logic        por         = 1'b1;
  logic        reset_pin_n = 1'b0;
  logic        irq_hv      = 1'b1;
  logic        div_sel     = 1'b1;
  logic        vec_blank   = 1'b0;
  logic        rst_hv      = 1'b0;
  logic        flash_x     = 1'b0;
  logic        illegal;
  logic        run_flag;
  logic        line;
  logic        pin_out;
  logic        pin_oe_n;
  logic [7:0]  mem_rdata   = 8'h00;
  logic [7:0]  mem [0:65535];
  mem_req_s    mem_req;
  mode_s       mode;
  logic        wdog_off;
  logic [15:0] rst_vec;
  logic [15:0] swi_vec;
  logic        sec_ok;
  int          mismatches  = 0;
  int          check_count = 0;

  always #50 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
  begin
    mem_rdata <= mem[mem_req.addr];
    if (mem_req.wr)
      mem[mem_req.addr] <= mem_req.wdata;
  end

  monitor_serial_debug dut (
    .clk_sys(clk_sys), .rst(rst), .por(por), .reset_pin_n(reset_pin_n),
    .irq_high_voltage(irq_hv), .rst_high_voltage(rst_hv),
    .clock_divide_select_pin(div_sel), .reset_vector_blank(vec_blank),
    .serial_comm_pin_in(line), .serial_comm_pin_out(pin_out),
    .serial_comm_pin_oe_n(pin_oe_n), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .flash_exec_attempt(flash_x), .mode(mode), .watchdog_disable(wdog_off),
    .reset_vector_addr(rst_vec), .swi_vector_addr(swi_vec), .security_ok(sec_ok),
    .illegal_addr_reset(illegal), .run_user(run_flag)
  );

  host_link host (.clk_sys(clk_sys), .dev_out(pin_out), .dev_oe_n(pin_oe_n), .line(line));

  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic rx(output logic [7:0] d, output logic s, output int gap);
    logic ok;
    host.recv_byte(d, s, ok, gap);
    if (ok !== 1'b1)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask : rx

  task automatic xfer(input logic [7:0] b);
    logic [7:0] d;
    logic       s;
    int         gap;
    host.send_byte(b);
    rx(d, s, gap);
    chk("echo", d, b);
    chk("echo_gap", (gap > BIT_CYCLES) && (gap < 3 * BIT_CYCLES), 1'b1);
  endtask : xfer

  task automatic do_reset(input logic power);
    @(posedge clk_sys);
    #1;
    rst = 1'b1;
    por = power;
    reset_pin_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    por = 1'b0;
    @(posedge clk_sys);
    #1;
    reset_pin_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : do_reset

  task automatic t_entry;
    div_sel = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("monitor", mode.monitor, 1'b1);
    chk("clk_div", mode.clk_div, DIV_BY_FOUR);
    chk("wdog", wdog_off, 1'b1);
    chk("rst_vec", rst_vec, VEC_RESET_MON);
    chk("swi_vec", swi_vec, VEC_SWI_MON);
    rst_hv = 1'b1;
    irq_hv = 1'b0;
    tick(3);
    chk("wdog_rst_hv", wdog_off, 1'b1);
    rst_hv = 1'b0;
    tick(3);
    chk("wdog_no_hv", wdog_off, 1'b0);
    irq_hv = 1'b1;
  endtask : t_entry

  task automatic t_security;
    logic [7:0] d;
    logic       s;
    int         gap;
    for (int i = 0; i < 8; i++)
      xfer(8'h30 + 8'(i));
    rx(d, s, gap);
    chk("break", {s, d}, 9'h000);
    chk("sec_ok", sec_ok, 1'b1);
  endtask : t_security

  task automatic t_read;
    logic [7:0] d;
    logic       s;
    int         gap;
    xfer(CMD_READ);
    xfer(8'h00);
    xfer(8'h41);
    rx(d, s, gap);
    chk("rd_data", d, 8'hA5);
    chk("flag", mem[FLAG_RAM_ADDR][FLAG_OK_BIT], 1'b1);
  endtask : t_read

  task automatic t_run;
    tick(CANCEL_BITS * BIT_CYCLES);
    xfer(CMD_RUN);
    chk("run", run_flag, 1'b1);
    flash_x = 1'b1;
    tick(2);
    chk("no_trap", illegal, 1'b0);
    flash_x = 1'b0;
  endtask : t_run

  task automatic t_resets;
    do_reset(1'b0);
    chk("keep_sec", sec_ok, 1'b1);
    chk("div_two", mode.clk_div, DIV_BY_TWO);
    irq_hv = 1'b0;
    vec_blank = 1'b1;
    do_reset(1'b1);
    chk("por_sec", sec_ok, 1'b0);
    chk("forced", mode.forced, 1'b1);
    chk("f_div", mode.clk_div, DIV_BY_FOUR);
    chk("f_wdog", wdog_off, 1'b1);
    flash_x = 1'b1;
    tick(2);
    chk("trap", illegal, 1'b1);
    flash_x = 1'b0;
  endtask : t_resets

  initial
  begin
    for (int i = 0; i < 8; i++)
      mem[SEC_BASE_ADDR + 16'(i)] = 8'h30 + 8'(i);
    mem[FLAG_RAM_ADDR] = 8'h00;
    mem[16'h0041] = 8'hA5;
    do_reset(1'b1);
    t_entry();
    t_security();
    t_read();
    t_run();
    t_resets();
    report_and_stop();
  end
endmodule : testbench
